// [hdl/arc_switch_cfg.sv]
// Auto-reclose switch groups and their control effects.
// Assumes an APB master on CLK_SYS_IN and asynchronous breaker pins.
//
// Functional notes
// - Group two has eight binary switches, group one seven, shown one at a time while setting.
// - Outside setting mode only a checksum per group is presented.
// - Checksum is the sum of weights of switches set to one.
// - Group one bits one to five enable shots one to five; default off.
// - Mode 00: closing in reclaim inhibits reclosing and final trip.
// - One mixed mode inhibits only reclosing during reclaim.
// - Other mixed mode makes closing harmless; 11 acts like 00.
// - Manual closing always aborts a running reclose sequence.
// - Group two bits one to five select synchro-check per shot.
// - With synchro-check, wait for synchro ok at most two seconds.
// - Group two bit six zero: monitor at zero only alarms.
// - Group two bit six one: monitor at zero blocks closing and reclosing.
// - Group two bit seven zero: position data present; one: absent.
// - Group two bit eight counts only while bit seven is one.
// - Absent data and bit eight zero: position input ignored.
// - Absent data and bit eight one: input is opening-coil voltage.
// - Absent data, protection final trip: definite trip only in coil mode.
`default_nettype none
`include "arc_consts.svh"

module arc_switch_cfg
    import arc_pkg::*;
#(
    parameter int SYNC_WAIT_CYCLES = `ARC_SYNC_WAIT_CYC
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output var  logic [31:0] PRDATA_OUT,
    output var  logic        PREADY_OUT,
    output var  logic        PSLVERR_OUT,
    input  wire logic        AR_START_IN,
    input  wire logic [2:0]  AR_SHOT_IN,
    input  wire logic        RECLAIM_RUN_IN,
    input  wire logic        AR_FINAL_TRIP_IN,
    input  wire logic        PROT_TRIP_IN,
    input  wire logic        MAINT_ZERO_IN,
    input  wire logic        CB_CLOSING_IN,
    input  wire logic        MAN_CLOSE_IN,
    input  wire logic        SYNCHRO_OK_INPUT_IN,
    input  wire logic        BREAKER_POSITION_INPUT_IN,
    output var  logic        CB_CLOSE_CMD_OUT,
    output var  logic        SYNC_WAIT_OUT,
    output var  logic        SEQ_ABORT_OUT,
    output var  logic        FINAL_TRIP_OUT,
    output var  logic        DEF_TRIP_OUT,
    output var  logic        AR_INHIBIT_OUT,
    output var  logic        MAINT_ALARM_OUT,
    output var  logic        CLOSE_BLOCK_OUT,
    output var  logic [7:0]  DISP_VALUE_OUT
);

    // =========================================================
    // State record.
    typedef struct packed {
        arc_state_t             state;
        logic [`ARC_CNT_W-1:0]  cnt;
        logic [2:0]             shot;
        logic [7:0]             cfg1;
        logic [7:0]             cfg2;
        logic                   set_mode;
        logic                   disp_grp;
        logic [2:0]             disp_sw;
        logic                   rcl_seen;
        logic                   cls_d;
        logic                   man_d;
        logic                   to_flag;
        logic                   abort_flag;
        logic                   def_flag;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic                   close_cmd;
        logic                   abort_p;
        logic                   ft_out;
        logic                   def_out;
        logic                   ar_inh;
        logic                   alarm;
        logic                   cl_block;
        logic [7:0]             disp;
    } arc_st_t;

    localparam logic [`ARC_CNT_W-1:0] WAIT_LAST =
        `ARC_CNT_W'(SYNC_WAIT_CYCLES - 1);

    arc_st_t    st_ff;
    arc_st_t    nxt_st;
    logic [3:0] pins_sync;

    // =========================================================
    // Pin synchronisers.
    arc_pin_sync #(
        .W (4)
    ) u_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_n_in (RESETN_IN),
        .pin_in   ({BREAKER_POSITION_INPUT_IN, SYNCHRO_OK_INPUT_IN,
                    MAN_CLOSE_IN, CB_CLOSING_IN}),
        .sync_out (pins_sync)
    );

    // =========================================================
    // Decoding helpers.

    // Per-shot bit; shots outside one to five select none.
    function automatic logic shot_bit(input logic [7:0] cfg,
                                      input logic [2:0] shot);
        logic r;
        r = 1'b0;
        if (shot >= 3'h1 && shot <= 3'h5) begin
            r = cfg[shot - 3'h1];
        end
        return r;
    endfunction

    // Reclaim closing mode from group one bits six and seven.
    function automatic arc_rcl_mode_t rcl_mode(input logic [7:0] cfg);
        arc_rcl_mode_t m;
        m = ARC_RCL_BOTH;
        if (cfg[`ARC_CFG1_MODE_LO] && !cfg[`ARC_CFG1_MODE_HI]) begin
            m = ARC_RCL_AR;
        end else if (!cfg[`ARC_CFG1_MODE_LO] && cfg[`ARC_CFG1_MODE_HI]) begin
            m = ARC_RCL_NONE;
        end
        return m;
    endfunction

    // Position input meaning from group two bits seven and eight.
    function automatic arc_pos_mode_t pos_mode(input logic [7:0] cfg);
        arc_pos_mode_t m;
        m = ARC_POS_PRESENT;
        if (cfg[`ARC_CFG2_NOPOS]) begin
            m = cfg[`ARC_CFG2_COIL] ? ARC_POS_COIL
                                    : ARC_POS_IGNORED;
        end
        return m;
    endfunction

    // Register read mux with error flag.
    function automatic logic [32:0] reg_read(input arc_st_t s,
                                             input logic [7:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (a == `ARC_OFF_CFG1) begin
            r[7:0] = s.cfg1 & `ARC_CFG_USED_MASK;
        end else if (a == `ARC_OFF_CFG2) begin
            r[7:0] = s.cfg2;
        end else if (a == `ARC_OFF_STATUS) begin
            r[3:0] = s.state;
            r[4]   = s.ar_inh;
            r[5]   = s.rcl_seen;
            r[7:6] = pos_mode(s.cfg2);
            r[`ARC_ST_TIMEOUT] = s.to_flag;
            r[`ARC_ST_ABORT]   = s.abort_flag;
            r[`ARC_ST_DEFTRIP] = s.def_flag;
        end else if (a == `ARC_OFF_DISP_CTRL) begin
            r[0]    = s.set_mode;
            r[4]    = s.disp_grp;
            r[10:8] = s.disp_sw;
        end else if (a == `ARC_OFF_DISP_VAL) begin
            r[7:0] = s.disp;
        end else begin
            r[32] = 1'b1;
        end
        return r;
    endfunction

    // =========================================================
    // Next-state logic.
    always_comb begin
        logic          wr;
        logic          cls_rise;
        logic          man_rise;
        logic          sync_ok;
        logic          pos_in;
        logic          ft_inh;
        logic          maint_blk;
        logic          brk_open;
        logic [32:0]   rd;
        logic [7:0]    grp;
        wr        = 1'b0;
        ft_inh    = 1'b0;
        maint_blk = 1'b0;
        brk_open  = 1'b0;
        rd        = '0;
        grp       = 8'h00;
        nxt_st    = st_ff;

        cls_rise  = pins_sync[0] && !st_ff.cls_d;
        man_rise  = pins_sync[1] && !st_ff.man_d;
        sync_ok   = pins_sync[2];
        pos_in    = pins_sync[3];
        nxt_st.cls_d = pins_sync[0];
        nxt_st.man_d = pins_sync[1];

        // APB slave: answer in the access cycle, one cycle after setup.
        nxt_st.pready = 1'b0;
        if (PSEL_IN && !PENABLE_IN) begin
            rd             = reg_read(st_ff, PADDR_IN);
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = rd[32];
            nxt_st.prdata  = PWRITE_IN ? 32'h0000_0000 : rd[31:0];
        end
        wr = PSEL_IN && PENABLE_IN && st_ff.pready && PWRITE_IN
             && !st_ff.pslverr;

        // Maintenance monitor: alarm always, block only when selected.
        nxt_st.alarm    = MAINT_ZERO_IN;
        maint_blk       = MAINT_ZERO_IN && st_ff.cfg2[`ARC_CFG2_MAINT];
        nxt_st.cl_block = maint_blk;

        // A closing seen while the reclaim time runs is held until it ends.
        if (!RECLAIM_RUN_IN) begin
            nxt_st.rcl_seen = 1'b0;
        end else if (cls_rise) begin
            nxt_st.rcl_seen = 1'b1;
        end
        nxt_st.ar_inh = 1'b0;
        case (rcl_mode(st_ff.cfg1))
            ARC_RCL_BOTH: begin
                nxt_st.ar_inh = nxt_st.rcl_seen;
                ft_inh        = st_ff.rcl_seen;
            end
            ARC_RCL_AR: begin
                nxt_st.ar_inh = nxt_st.rcl_seen;
            end
            default: begin
                nxt_st.ar_inh = 1'b0;
            end
        endcase
        nxt_st.ar_inh = nxt_st.ar_inh || maint_blk;

        // Reclose sequence.
        nxt_st.close_cmd = 1'b0;
        nxt_st.abort_p   = 1'b0;
        case (st_ff.state)
            ARC_IDLE: begin
                nxt_st.cnt = '0;
                if (AR_START_IN && shot_bit(st_ff.cfg1, AR_SHOT_IN)
                    && !st_ff.ar_inh && !maint_blk) begin
                    nxt_st.shot = AR_SHOT_IN;
                    if (shot_bit(st_ff.cfg2, AR_SHOT_IN)) begin
                        nxt_st.state = ARC_SYNC;
                    end else begin
                        nxt_st.state = ARC_CLOSE;
                    end
                end
            end
            ARC_SYNC: begin
                nxt_st.cnt = st_ff.cnt + `ARC_CNT_W'(1);
                if (man_rise) begin
                    nxt_st.state   = ARC_IDLE;
                    nxt_st.abort_p = 1'b1;
                end else if (sync_ok) begin
                    nxt_st.state = ARC_CLOSE;
                end else if (st_ff.cnt >= WAIT_LAST) begin
                    nxt_st.state   = ARC_IDLE;
                    nxt_st.to_flag = 1'b1;
                end
            end
            ARC_CLOSE: begin
                nxt_st.state = ARC_IDLE;
                if (man_rise) begin
                    nxt_st.abort_p = 1'b1;
                end else if (!maint_blk) begin
                    nxt_st.close_cmd = 1'b1;
                end
            end
            default: begin
                nxt_st.state = ARC_IDLE;
            end
        endcase

        // Final trip and definite-trip indication.
        nxt_st.ft_out  = AR_FINAL_TRIP_IN && !ft_inh;
        nxt_st.def_out = 1'b0;
        case (pos_mode(st_ff.cfg2))
            ARC_POS_PRESENT: brk_open = !pos_in;
            ARC_POS_COIL:    brk_open = pos_in;
            default:         brk_open = 1'b0;
        endcase
        if (nxt_st.ft_out && PROT_TRIP_IN && brk_open) begin
            nxt_st.def_out = 1'b1;
        end

        // Register writes; a hardware set in the same cycle wins, except a timeout while the timeout flag is already set.
        if (wr) begin
            if (PADDR_IN == `ARC_OFF_CFG1) begin
                nxt_st.cfg1 = PWDATA_IN[7:0] & `ARC_CFG_USED_MASK;
            end else if (PADDR_IN == `ARC_OFF_CFG2) begin
                nxt_st.cfg2 = PWDATA_IN[7:0];
            end else if (PADDR_IN == `ARC_OFF_STATUS) begin
                if (PWDATA_IN[`ARC_ST_TIMEOUT]
                    && nxt_st.to_flag == st_ff.to_flag) begin
                    nxt_st.to_flag = 1'b0;
                end
                if (PWDATA_IN[`ARC_ST_ABORT] && !nxt_st.abort_p) begin
                    nxt_st.abort_flag = 1'b0;
                end
                if (PWDATA_IN[`ARC_ST_DEFTRIP] && !nxt_st.def_out) begin
                    nxt_st.def_flag = 1'b0;
                end
            end else if (PADDR_IN == `ARC_OFF_DISP_CTRL) begin
                nxt_st.set_mode = PWDATA_IN[0];
                nxt_st.disp_grp = PWDATA_IN[4];
                nxt_st.disp_sw  = PWDATA_IN[10:8];
            end
        end
        if (nxt_st.abort_p) begin
            nxt_st.abort_flag = 1'b1;
        end
        if (nxt_st.def_out) begin
            nxt_st.def_flag = 1'b1;
        end

        // Display: one switch while setting, else the group checksum.
        grp = st_ff.disp_grp ? st_ff.cfg2 : st_ff.cfg1;
        if (st_ff.set_mode) begin
            nxt_st.disp = {7'h00, grp[st_ff.disp_sw]};
        end else begin
            nxt_st.disp = grp;
        end
    end

    // =========================================================
    // State register; every field resets to a constant.
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_ff       <= '0;
            st_ff.state <= ARC_IDLE;
            st_ff.cfg1  <= `ARC_CFG_RESET;
            st_ff.cfg2  <= `ARC_CFG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // Outputs straight from the state register.
    assign PRDATA_OUT       = st_ff.prdata;
    assign PREADY_OUT       = st_ff.pready;
    assign PSLVERR_OUT      = st_ff.pslverr;
    assign CB_CLOSE_CMD_OUT = st_ff.close_cmd;
    assign SYNC_WAIT_OUT    = st_ff.state == ARC_SYNC;
    assign SEQ_ABORT_OUT    = st_ff.abort_p;
    assign FINAL_TRIP_OUT   = st_ff.ft_out;
    assign DEF_TRIP_OUT     = st_ff.def_out;
    assign AR_INHIBIT_OUT   = st_ff.ar_inh;
    assign MAINT_ALARM_OUT  = st_ff.alarm;
    assign CLOSE_BLOCK_OUT  = st_ff.cl_block;
    assign DISP_VALUE_OUT   = st_ff.disp;

endmodule // arc_switch_cfg

`default_nettype wire

// [hdl/arc_consts.svh]
// Constants of the auto-reclose switch block.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// =============================================================
// Clock and timing
`define ARC_CLK_HZ          40000000
`define ARC_SYNC_WAIT_MS    2000
`define ARC_SYNC_WAIT_CYC   (`ARC_SYNC_WAIT_MS * (`ARC_CLK_HZ / 1000))
`define ARC_CNT_W           27

// =============================================================
// Register byte offsets
`define ARC_OFF_CFG1        8'h00
`define ARC_OFF_CFG2        8'h04
`define ARC_OFF_STATUS      8'h08
`define ARC_OFF_DISP_CTRL   8'h0C
`define ARC_OFF_DISP_VAL    8'h10

// =============================================================
// Reset values and field positions
`define ARC_CFG_RESET       8'h00
`define ARC_CFG_USED_MASK   8'h7F
`define ARC_SHOTS           5
`define ARC_CFG1_MODE_LO    5
`define ARC_CFG1_MODE_HI    6
`define ARC_CFG2_MAINT      5
`define ARC_CFG2_NOPOS      6
`define ARC_CFG2_COIL       7
`define ARC_ST_TIMEOUT      8
`define ARC_ST_ABORT        9
`define ARC_ST_DEFTRIP      10

`endif

// [hdl/arc_pkg.sv]
// Types of the auto-reclose switch block.
// Assumes arc_consts.svh is on the include path.
`default_nettype none

package arc_pkg;

    // =========================================================
    // Sequence states, one-hot.
    typedef enum logic [3:0] {
        ARC_IDLE  = 4'h1,
        ARC_SYNC  = 4'h2,
        ARC_CLOSE = 4'h4,
        ARC_SPARE = 4'h8
    } arc_state_t;

    // Breaker position input interpretation.
    typedef enum logic [1:0] {
        ARC_POS_PRESENT = 2'h0,
        ARC_POS_IGNORED = 2'h1,
        ARC_POS_COIL    = 2'h2
    } arc_pos_mode_t;

    // Effect of a breaker closing during the reclaim time.
    typedef enum logic [1:0] {
        ARC_RCL_BOTH = 2'h0,
        ARC_RCL_AR   = 2'h1,
        ARC_RCL_NONE = 2'h2
    } arc_rcl_mode_t;

endpackage : arc_pkg

`default_nettype wire

// [hdl/arc_pin_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins.
`default_nettype none

module arc_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } arc_sync_st_t;

    arc_sync_st_t st_ff;
    arc_sync_st_t nxt_st;

    // =========================================================
    // Stage one feeds only stage two; the filter looks at two and three.
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    // Register update.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.q;

endmodule // arc_pin_sync

`default_nettype wire

// [bench/arc_switch_cfg_checker.sv]
// Assertions on the ports of the auto-reclose switch block.
// Assumes one clock and an active-low reset.
`default_nettype none

module arc_switch_cfg_checker #(
    parameter int SYNC_WAIT_CYCLES = 20
) (
    input wire logic        CLK_SYS_IN,
    input wire logic        RESETN_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        AR_FINAL_TRIP_IN,
    input wire logic        PROT_TRIP_IN,
    input wire logic        MAINT_ZERO_IN,
    input wire logic        CB_CLOSE_CMD_OUT,
    input wire logic        SYNC_WAIT_OUT,
    input wire logic        SEQ_ABORT_OUT,
    input wire logic        FINAL_TRIP_OUT,
    input wire logic        DEF_TRIP_OUT,
    input wire logic        MAINT_ALARM_OUT,
    input wire logic        CLOSE_BLOCK_OUT
);
    timeunit 1ns;
    timeprecision 100ps;

    // Length of the running synchro wait.
    logic [31:0] wait_len_ff;
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wait_len_ff <= 32'h0;
        end else begin
            wait_len_ff <= SYNC_WAIT_OUT ? wait_len_ff + 32'h1 : 32'h0;
        end
    end

    // =========================================================
    // Properties
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    a_bit_eight_zero: assert property (
        PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h00
        |-> PRDATA_OUT[31:7] == 25'h0) else $error("unused bit set");
    a_alarm_follows: assert property (
        MAINT_ZERO_IN |=> MAINT_ALARM_OUT) else $error("alarm missing");
    a_block_cause: assert property (
        CLOSE_BLOCK_OUT |-> $past(MAINT_ZERO_IN)) else $error("bad block");
    a_block_no_close: assert property (
        CLOSE_BLOCK_OUT && $past(CLOSE_BLOCK_OUT) |-> !CB_CLOSE_CMD_OUT)
        else $error("close while blocked");
    a_final_cause: assert property (
        FINAL_TRIP_OUT |-> $past(AR_FINAL_TRIP_IN)) else $error("bad trip");
    a_def_trip_cause: assert property (
        DEF_TRIP_OUT |-> FINAL_TRIP_OUT && $past(PROT_TRIP_IN))
        else $error("bad definite trip");
    a_abort_no_close: assert property (
        SEQ_ABORT_OUT |-> !CB_CLOSE_CMD_OUT [*4]) else $error("closed");
    a_wait_bounded: assert property (
        wait_len_ff <= SYNC_WAIT_CYCLES + 4) else $error("wait too long");

    c_close: cover property (CB_CLOSE_CMD_OUT);
    c_abort: cover property (SEQ_ABORT_OUT);
    c_def_trip: cover property (DEF_TRIP_OUT);
endmodule // arc_switch_cfg_checker

bind arc_switch_cfg arc_switch_cfg_checker #(
    .SYNC_WAIT_CYCLES(SYNC_WAIT_CYCLES)
) i_chk (.*);

`default_nettype wire

// [bench/arc_breaker_model.sv]
// Breaker and synchro relay model.
// Assumes requests arrive after a rising edge.
`default_nettype none

module arc_breaker_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       close_cmd_in,
    input  wire logic       make_req_in,
    input  wire logic       man_req_in,
    input  wire logic       open_req_in,
    input  wire logic       coil_in,
    input  wire logic       wait_in,
    input  wire logic [7:0] sync_after_in,
    output var  logic       closed_out,
    output var  logic       man_pin_out,
    output var  logic       sync_ok_out,
    output var  logic       pos_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       closed_ff;
    logic [7:0] wait_cnt_ff;

    // Contacts make on any close, part on request.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            closed_ff   <= 1'b0;
            wait_cnt_ff <= 8'h00;
        end else begin
            if (close_cmd_in || make_req_in || man_req_in) begin
                closed_ff <= 1'b1;
            end else if (open_req_in) begin
                closed_ff <= 1'b0;
            end
            wait_cnt_ff <= wait_in ? wait_cnt_ff + 8'h01 : 8'h00;
        end
    end

    // Zero delay: never in step.
    assign sync_ok_out = wait_in && sync_after_in != 8'h00
                         && wait_cnt_ff >= sync_after_in;
    assign closed_out  = closed_ff;
    assign man_pin_out = man_req_in;
    assign pos_out     = closed_ff | coil_in;
endmodule // arc_breaker_model

`default_nettype wire

// [bench/arc_switch_cfg_bench.sv]
// Bench for the auto-reclose switch block over APB.
// Assumes the design, checker and breaker model.
`default_nettype none

`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin \
    fails++; $display("unexpected %s exp %0h got %0h", nm, x, g); end end

module arc_switch_cfg_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // Expected bits per mode.
    localparam logic [3:0] inh_x = 4'hB;
    localparam logic [3:0] fin_x = 4'h6;
    localparam logic [7:0] pm_x  = 8'h84;
    localparam logic [3:0] dt_x  = 4'hD;
    localparam logic [7:0] pat   = 8'hA5;

    logic        clk, rst_n, psel, pen, pwr, start, reclaim, arft, prot;
    logic        maint, man_req, make_req, open_req, coil, cb_close;
    logic        pready, pslverr, sync_wait, seq_abort, fin_trip, def_trip;
    logic        ar_inh, alarm, blk, closed, man_pin, sync_ok, pos;
    logic [2:0]  shot;
    logic [7:0]  paddr, sync_after, disp;
    logic [31:0] pwdata, prdata;
    int          fails, n_checks;

    arc_switch_cfg #(.SYNC_WAIT_CYCLES(20)) i_dut (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .AR_START_IN(start), .AR_SHOT_IN(shot),
        .RECLAIM_RUN_IN(reclaim), .AR_FINAL_TRIP_IN(arft),
        .PROT_TRIP_IN(prot), .MAINT_ZERO_IN(maint),
        .CB_CLOSING_IN(closed), .MAN_CLOSE_IN(man_pin),
        .SYNCHRO_OK_INPUT_IN(sync_ok), .BREAKER_POSITION_INPUT_IN(pos),
        .CB_CLOSE_CMD_OUT(cb_close), .SYNC_WAIT_OUT(sync_wait),
        .SEQ_ABORT_OUT(seq_abort), .FINAL_TRIP_OUT(fin_trip),
        .DEF_TRIP_OUT(def_trip), .AR_INHIBIT_OUT(ar_inh),
        .MAINT_ALARM_OUT(alarm), .CLOSE_BLOCK_OUT(blk),
        .DISP_VALUE_OUT(disp)
    );

    arc_breaker_model i_cb (
        .clk_in(clk), .rst_n_in(rst_n), .close_cmd_in(cb_close),
        .make_req_in(make_req), .man_req_in(man_req),
        .open_req_in(open_req), .coil_in(coil), .wait_in(sync_wait),
        .sync_after_in(sync_after), .closed_out(closed),
        .man_pin_out(man_pin), .sync_ok_out(sync_ok), .pos_out(pos)
    );

    // =========================================================
    // Clock, tasks and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // One APB transfer, then an idle edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(negedge clk); while (pready !== 1'b1 && ++n < 16);
        if (pready !== 1'b1) fails++;
        r = prdata;
        e = pslverr;
        @(posedge clk);
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("rdata", x, r & m)
        `CHK("slverr", xe, e)
    endtask

    // Requests a shot and watches it for a fixed span.
    task automatic go(input logic [2:0] s, input logic xc, input logic xw,
                      input logic mc);
        logic c, w, ab;
        {c, w, ab} = 3'h0;
        {start, shot} <= {1'b1, s};
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 60; n++) begin
            man_req <= mc && n >= 4 && n < 8;
            @(negedge clk);
            {c, w, ab} = {c | cb_close, w | sync_wait, ab | seq_abort};
            @(posedge clk);
        end
        `CHK("close", xc, c)
        `CHK("sync_wait", xw, w)
        `CHK("abort", mc, ab)
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        end_sim();
    end

    // =========================================================
    // Test sequence
    initial begin
        {psel, pen, pwr, start, reclaim, arft, prot, maint} = 8'h00;
        {man_req, make_req, open_req, coil, rst_n} = 5'h00;
        {paddr, sync_after, pwdata, shot, fails, n_checks} = 115'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(8'h04, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(8'h14, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(8'h00, 32'h000000FF);
        rd(8'h00, 32'hFFFFFFFF, 32'h0000007F, 1'b0);
        wr(8'h04, {24'h0, pat});
        rd(8'h04, 32'hFFFFFFFF, {24'h0, pat}, 1'b0);
        tick(2);
        `CHK("checksum1", 8'h7F, disp)
        rd(8'h10, 32'hFF, 32'h7F, 1'b0);
        wr(8'h0C, 32'h00000010);
        tick(2);
        `CHK("checksum2", pat, disp)
        for (int i = 0; i < 8; i++) begin
            wr(8'h0C, {21'h0, i[2:0], 8'h11});
            tick(2);
            `CHK("switch", {7'h0, pat[i]}, disp)
        end
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h0);
        for (int s = 1; s <= 5; s++) begin
            wr(8'h00, 32'h1 << (s - 1));
            go(s[2:0], 1'b1, 1'b0, 1'b0);
            go(s[2:0] % 3'h5 + 3'h1, 1'b0, 1'b0, 1'b0);
        end
        go(3'h6, 1'b0, 1'b0, 1'b0);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h1);
        sync_after <= 8'h0A;
        go(3'h1, 1'b1, 1'b1, 1'b0);
        sync_after <= 8'h00;
        go(3'h1, 1'b0, 1'b1, 1'b0);
        rd(8'h08, 32'h100, 32'h100, 1'b0);
        go(3'h1, 1'b0, 1'b1, 1'b1);
        rd(8'h08, 32'h200, 32'h200, 1'b0);
        wr(8'h08, 32'h300);
        rd(8'h08, 32'h300, 32'h0, 1'b0);
        wr(8'h04, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, {25'h0, m[1:0], 5'h01});
            {open_req, reclaim} <= 2'b11;
            tick(8);
            {open_req, make_req} <= 2'b01;
            tick(1);
            {make_req, arft} <= 2'b01;
            tick(10);
            `CHK("inhibit", inh_x[m], ar_inh)
            `CHK("final", fin_x[m], fin_trip)
            go(3'h1, ~inh_x[m], 1'b0, 1'b0);
            {arft, reclaim} <= 2'b00;
            tick(4);
            `CHK("inhibit_end", 1'b0, ar_inh)
        end
        for (int b = 0; b < 2; b++) begin
            wr(8'h04, {26'h0, b[0], 5'h00});
            maint <= 1'b1;
            tick(3);
            `CHK("alarm", 1'b1, alarm)
            `CHK("block", b[0], blk)
            `CHK("inh_block", b[0], ar_inh)
            go(3'h1, ~b[0], 1'b0, 1'b0);
            maint <= 1'b0;
            tick(2);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, {24'h0, k[1:0], 6'h00});
            {coil, open_req, prot} <= {k[0], 2'b11};
            tick(8);
            rd(8'h08, 32'hC0, {24'h0, pm_x[2*k +: 2], 6'h0}, 1'b0);
            {open_req, arft} <= 2'b01;
            tick(3);
            `CHK("def_trip", dt_x[k], def_trip)
            {arft, prot} <= 2'b00;
            tick(2);
        end
        end_sim();
    end
endmodule // arc_switch_cfg_bench

`default_nettype wire
